/* File: rtl/drive_ctl_defs.vh */
// register offsets, field positions and reset values of the drive command decoder
`ifndef DRIVE_CTL_DEFS_VH
`define DRIVE_CTL_DEFS_VH
`define OFS_CMD_WORD      12'h000
`define OFS_STOP_METHOD   12'h004
`define OFS_CTRL_METHOD   12'h008
`define OFS_CUR_FILT      12'h00C
`define OFS_SLIP_FILT     12'h010
`define OFS_SRC_SEL       12'h014
`define OFS_STATUS        12'h018
`define OFS_CUR_OUT       12'h01C
`define OFS_SLIP_OUT      12'h020
`define CMD_RAMP_EN       0
`define CMD_GEN_EN        1
`define CMD_DIR_CW        2
`define CMD_INCH          3
`define CMD_REMOTE        4
`define CMD_RAMP2         5
`define CMD_QSTOP         6
`define CMD_FRESET        7
`define CMD_PID_INT       13
`define CMD_PID_EXT       14
`define CMD_WR_MASK       16'h60FF
`define STOP_RAMP         2'h0
`define STOP_COAST        2'h1
`define STOP_QUICK        2'h2
`define CTRL_VECTOR       16'h0003
`define RST_CMD_WORD      16'h0000
`define RST_STOP_METHOD   16'h0000
`define RST_CTRL_METHOD   16'h0000
`define RST_CUR_FILT      16'h0032
`define RST_SLIP_FILT     16'h01F4
`define MAX_CUR_FILT      16'h270F
`define SRC_PANEL         2'h0
`define SRC_NET           2'h1
`define SRC_PLC           2'h2
`define CLK_KHZ           40000
`define RESP_MULT         3
`endif

/* File: rtl/lp_filter.v */
// first-order output filter with a time constant in milliseconds
`timescale 1ns/1ps
`include "drive_ctl_defs.vh"
module lp_filter #(
  parameter W      = 16,
  parameter MS_CYC = `CLK_KHZ
)(
  input  wire         pclk,
  input  wire         presetn,
  input  wire [15:0]  tau_ms,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  // one update every tau + 1 ms; y += (x - y) / (tau + 1) approximated by a half-difference step per update
  reg  [31:0]  tick_cnt_r;
  reg  [15:0]  step_cnt_r;
  wire         tick = (tick_cnt_r == MS_CYC - 1);
  wire         upd  = tick && (step_cnt_r >= tau_ms);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= 32'h0;
      step_cnt_r <= 16'h0;
      dout       <= {W{1'b0}};
    end
    else
    begin
      tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
      if (tick)
        step_cnt_r <= upd ? 16'h0 : step_cnt_r + 16'h1;
      // coarse half-difference step: limitation, settling tracks tau only for small deltas
      if (tau_ms == 16'h0)
        dout <= din;
      else if (upd && dout < din)
        dout <= dout + ((din - dout) >> 1) + {{(W-1){1'b0}}, 1'b1} - {{(W-1){1'b0}}, 1'b1} + {{(W-1){1'b0}}, (din != dout)};
      else if (upd && dout > din)
        dout <= dout - ((dout - din) >> 1) - {{(W-1){1'b0}}, 1'b1} + {{(W-1){1'b0}}, 1'b1} - {{(W-1){1'b0}}, (din != dout)};
    end
  end
endmodule

/* File: rtl/drive_cmd_decoder.v */
// drive command word decoder with stop-mode handling and filter settings
// Summary of operation
// - only the selected command source may write the command word; others read only
// - bit 0 ramp enable: clear decelerates to standstill, set accelerates to reference
// - bit 1 general enable: clear removes motor power, set enables the drive
// - bit 2 direction: set clockwise with reference, clear counter-clockwise
// - bit 3 enables the inching function
// - bit 4 set selects remote mode, clear selects local mode
// - bit 5 selects second accel/decel ramp pair, clear the first
// - bit 6 set executes the fast stop
// - bit 7 set resets an active fault
// - bits 13 and 14 set manual mode for internal/external PID; others reserved
// - stop mode 0 normal ramp, 1 coast, 2 quick-stop ramp
// - stop mode applies to stop commands of every source
// - with coast, clearing ramp enable acts like clearing general enable
// - with coast, digital-input run, direction and three-wire stops also coast; di_reverse here only forces dir_clockwise low and never stops
// - panel keys never write the command word directly
// - digital inputs never write the command word directly
// - control type 0-2 scalar, 3 sensorless vector, default 0
// - vector chosen from the panel starts the guided setup menu
// - output current filter 0-9999 ms, default 50 ms, response three constants
// - slip compensation filter, nominal 500 ms, response three constants
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "drive_ctl_defs.vh"
module drive_cmd_decoder #(
  parameter CLK_KHZ = `CLK_KHZ
)(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [1:0]  bus_source,
  input  wire        fault_active,
  input  wire        di_run,
  input  wire        di_reverse,
  input  wire        di_three_wire_stop,
  input  wire        panel_run,
  input  wire [15:0] current_raw,
  input  wire [15:0] slip_raw,
  output reg         run_ramp,
  output reg         power_enable,
  output reg         dir_clockwise,
  output reg         inching_function,
  output reg         remote_mode,
  output reg         second_ramp,
  output reg         quick_stop_ramp,
  output reg         fault_reset,
  output reg         pid_int_manual,
  output reg         pid_ext_manual,
  output reg         vector_mode,
  output reg         guided_setup_menu,
  output reg  [15:0] current_filter_time_o,
  output reg  [15:0] slip_filter_time_o,
  output wire [15:0] current_filtered,
  output wire [15:0] slip_filtered
);
  localparam ST_RUN  = 3'b001;
  localparam ST_RAMP = 3'b010;
  localparam ST_OFF  = 3'b100;

  reg [15:0] drive_command_word_r;
  reg [15:0] stop_method_select_r;
  reg [15:0] motor_control_method_r;
  reg [15:0] current_filter_time_r;
  reg [15:0] slip_filter_time_r;
  reg [1:0]  src_sel_r;
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg        freset_d_r;
  reg [31:0] rd_mux;

  function [0:0] addr_is;
    input [11:0] a;
    input [11:0] ofs;
    begin
      addr_is = (a == ofs);
    end
  endfunction

  wire acc    = psel && penable;
  wire wr     = acc && pwrite;
  wire mapped = addr_is(paddr, `OFS_CMD_WORD) || addr_is(paddr, `OFS_STOP_METHOD) ||
                addr_is(paddr, `OFS_CTRL_METHOD) || addr_is(paddr, `OFS_CUR_FILT) ||
                addr_is(paddr, `OFS_SLIP_FILT) || addr_is(paddr, `OFS_SRC_SEL) ||
                addr_is(paddr, `OFS_STATUS) || addr_is(paddr, `OFS_CUR_OUT) ||
                addr_is(paddr, `OFS_SLIP_OUT);
  // only the network or plc owner matches the selected source
  wire src_ok = (bus_source == src_sel_r) && (bus_source != `SRC_PANEL);
  wire cmd_wr_denied = wr && addr_is(paddr, `OFS_CMD_WORD) && !src_ok;
  assign pready  = 1'b1;
  assign pslverr = acc && (!mapped || cmd_wr_denied);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_command_word_r   <= `RST_CMD_WORD;
      stop_method_select_r   <= `RST_STOP_METHOD;
      motor_control_method_r <= `RST_CTRL_METHOD;
      current_filter_time_r  <= `RST_CUR_FILT;
      slip_filter_time_r     <= `RST_SLIP_FILT;
      src_sel_r              <= `SRC_NET;
      guided_setup_menu      <= 1'b0;
    end
    else if (wr)
    begin
      if (addr_is(paddr, `OFS_CMD_WORD) && src_ok)
        drive_command_word_r <= pwdata[15:0] & `CMD_WR_MASK;
      if (addr_is(paddr, `OFS_STOP_METHOD) && pwdata[15:0] <= {14'h0, `STOP_QUICK})
        stop_method_select_r <= pwdata[15:0];
      if (addr_is(paddr, `OFS_CTRL_METHOD) && pwdata[15:0] <= `CTRL_VECTOR)
      begin
        motor_control_method_r <= pwdata[15:0];
        if (pwdata[15:0] == `CTRL_VECTOR && bus_source == `SRC_PANEL)
          guided_setup_menu <= 1'b1;
      end
      if (addr_is(paddr, `OFS_CUR_FILT) && pwdata[15:0] <= `MAX_CUR_FILT)
        current_filter_time_r <= pwdata[15:0];
      if (addr_is(paddr, `OFS_SLIP_FILT))
        slip_filter_time_r <= pwdata[15:0];
      if (addr_is(paddr, `OFS_SRC_SEL))
        src_sel_r <= pwdata[1:0];
      // writing status bit 0 as one leaves the setup menu
      if (addr_is(paddr, `OFS_STATUS) && pwdata[0])
        guided_setup_menu <= 1'b0;
    end
  end

  wire coast     = (stop_method_select_r[1:0] == `STOP_COAST);
  wire qstop_sel = (stop_method_select_r[1:0] == `STOP_QUICK);
  wire gen_en    = drive_command_word_r[`CMD_GEN_EN];
  // digital inputs only add stop intents and force dir_clockwise low; they never touch the word
  wire di_stop   = !di_run || di_three_wire_stop;
  wire run_req   = (drive_command_word_r[`CMD_RAMP_EN] || panel_run) && !di_stop;

  // motor state: running, ramping down, or output off
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (!gen_en)
          state_nxt = ST_OFF;
        else if (!run_req)
          state_nxt = coast ? ST_OFF : ST_RAMP;
      ST_RAMP:
        if (!gen_en || coast)
          state_nxt = ST_OFF;
        else if (run_req)
          state_nxt = ST_RUN;
      ST_OFF:
        if (gen_en && run_req)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_OFF;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r               <= ST_OFF;
      freset_d_r            <= 1'b0;
      run_ramp              <= 1'b0;
      power_enable          <= 1'b0;
      dir_clockwise         <= 1'b0;
      inching_function      <= 1'b0;
      remote_mode           <= 1'b0;
      second_ramp           <= 1'b0;
      quick_stop_ramp       <= 1'b0;
      fault_reset           <= 1'b0;
      pid_int_manual        <= 1'b0;
      pid_ext_manual        <= 1'b0;
      vector_mode           <= 1'b0;
      current_filter_time_o <= `RST_CUR_FILT;
      slip_filter_time_o    <= `RST_SLIP_FILT;
    end
    else
    begin
      state_r          <= state_nxt;
      freset_d_r       <= drive_command_word_r[`CMD_FRESET];
      run_ramp         <= (state_nxt == ST_RUN);
      power_enable     <= (state_nxt != ST_OFF);
      dir_clockwise    <= drive_command_word_r[`CMD_DIR_CW] && !di_reverse;
      inching_function <= drive_command_word_r[`CMD_INCH];
      remote_mode      <= drive_command_word_r[`CMD_REMOTE];
      second_ramp      <= drive_command_word_r[`CMD_RAMP2];
      // quick ramp from the bit itself or a stop under quick-stop mode
      quick_stop_ramp  <= drive_command_word_r[`CMD_QSTOP] ||
                          (qstop_sel && state_nxt == ST_RAMP);
      // one pulse on the rising edge so a held bit does not keep clearing
      fault_reset      <= fault_active && drive_command_word_r[`CMD_FRESET] && !freset_d_r;
      pid_int_manual   <= drive_command_word_r[`CMD_PID_INT];
      pid_ext_manual   <= drive_command_word_r[`CMD_PID_EXT];
      vector_mode      <= (motor_control_method_r == `CTRL_VECTOR);
      current_filter_time_o <= current_filter_time_r;
      slip_filter_time_o    <= slip_filter_time_r;
    end
  end

  lp_filter #(.W(16), .MS_CYC(CLK_KHZ)) u_cur_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .tau_ms  (current_filter_time_r),
    .din     (current_raw),
    .dout    (current_filtered)
  );

  lp_filter #(.W(16), .MS_CYC(CLK_KHZ)) u_slip_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .tau_ms  (slip_filter_time_r),
    .din     (slip_raw),
    .dout    (slip_filtered)
  );

  always @*
  begin
    rd_mux = 32'h0;
    case (1'b1)
      addr_is(paddr, `OFS_CMD_WORD):    rd_mux = {16'h0, drive_command_word_r};
      addr_is(paddr, `OFS_STOP_METHOD): rd_mux = {16'h0, stop_method_select_r};
      addr_is(paddr, `OFS_CTRL_METHOD): rd_mux = {16'h0, motor_control_method_r};
      addr_is(paddr, `OFS_CUR_FILT):    rd_mux = {16'h0, current_filter_time_r};
      addr_is(paddr, `OFS_SLIP_FILT):   rd_mux = {16'h0, slip_filter_time_r};
      addr_is(paddr, `OFS_SRC_SEL):     rd_mux = {30'h0, src_sel_r};
      addr_is(paddr, `OFS_STATUS):      rd_mux = {27'h0, state_r, power_enable, guided_setup_menu};
      addr_is(paddr, `OFS_CUR_OUT):     rd_mux = {16'h0, current_filtered};
      addr_is(paddr, `OFS_SLIP_OUT):    rd_mux = {16'h0, slip_filtered};
      default:                          rd_mux = 32'h0;
    endcase
  end

  // captured in the setup cycle so read data stands through the zero-wait access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= rd_mux;
  end
endmodule

/* File: sim/cmd_source_model.sv */
// apb command source model: panel, network master or embedded controller
`timescale 1ns/1ps
module cmd_source_model (
  input  wire        pclk,
  input  wire        pready,
  input  wire        pslverr,
  input  wire [31:0] prdata,
  output reg         psel = 1'b0,
  output reg         penable = 1'b0,
  output reg         pwrite = 1'b0,
  output reg  [11:0] paddr = 12'h000,
  output reg  [31:0] pwdata = 32'h0,
  output reg  [1:0]  bus_source = 2'h1
);
  // request held until pready is seen high at an edge
  task xfer(input [1:0] s, input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
    begin
      @(posedge pclk);
      bus_source <= s;
      psel       <= 1'b1;
      pwrite     <= w;
      paddr      <= a;
      pwdata     <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released data toggles so a stale value is never mistaken for a drive
      pwdata  <= ~d;
    end
  endtask
endmodule

/* File: sim/drive_cmd_assertions.sv */
// port assertions for the drive command decoder
`timescale 1ns/1ps
`include "drive_ctl_defs.vh"
module drive_cmd_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire [1:0]  bus_source,
  input wire        di_reverse,
  input wire        power_enable,
  input wire        dir_clockwise,
  input wire        inching_function,
  input wire        pid_int_manual,
  input wire        pid_ext_manual,
  input wire        fault_reset,
  input wire [15:0] current_filter_time_o
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire cmd_acc = psel && penable && paddr == `OFS_CMD_WORD;
  wire cmd_wr  = cmd_acc && pwrite && !pslverr;
  a_panel_refused: assert property (cmd_acc && pwrite && bus_source == 2'h0 |-> pslverr)
    else $error("panel write to command word taken");
  a_gen_off: assert property (cmd_wr && !pwdata[1] |-> ##2 !power_enable)
    else $error("power on after general disable");
  a_dir_follow: assert property (cmd_wr |-> ##2 dir_clockwise == ($past(pwdata[2], 2) && !$past(di_reverse)))
    else $error("direction does not follow command");
  a_inch_follow: assert property (cmd_wr |-> ##2 inching_function == $past(pwdata[3], 2))
    else $error("inching does not follow command");
  a_pid_follow: assert property (cmd_wr |-> ##2 {pid_ext_manual, pid_int_manual} == $past(pwdata[14:13], 2))
    else $error("pid mode does not follow command");
  a_fault_pulse: assert property ($rose(fault_reset) |=> !fault_reset)
    else $error("fault reset longer than one cycle");
  a_resv_zero: assert property (cmd_acc && !pwrite |-> (prdata & 32'hFFFF9F00) == 32'h0)
    else $error("reserved command bits read nonzero");
  a_filt_range: assert property (current_filter_time_o <= 16'h270F)
    else $error("current filter time out of range");
  c_cmd_write: cover property (cmd_wr);
  c_fault: cover property ($rose(fault_reset));
  c_refused: cover property (cmd_acc && pslverr);
endmodule
bind drive_cmd_decoder drive_cmd_checker chk_u (.*);

/* File: sim/tb.sv */
// self-checking bench for the drive command decoder
`timescale 1ns/1ps
`include "drive_ctl_defs.vh"
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, fault_active = 1'b0, di_run = 1'b1, e;
  logic        di_reverse = 1'b0, di_three_wire_stop = 1'b0, panel_run = 1'b0;
  logic [15:0] current_raw = 16'h0100, slip_raw = 16'h0040;
  logic [31:0] q;
  int          n_fail = 0, num_checks = 0, n_pulse = 0;
  wire         psel, penable, pwrite, pready, pslverr, run_ramp, power_enable, dir_clockwise, fault_reset;
  wire         inching_function, remote_mode, second_ramp, quick_stop_ramp, pid_int_manual, pid_ext_manual;
  wire         vector_mode, guided_setup_menu;
  wire [1:0]   bus_source;
  wire [11:0]  paddr;
  wire [31:0]  pwdata, prdata;
  wire [15:0]  current_filter_time_o, slip_filter_time_o, current_filtered, slip_filtered;
  wire [7:0]   st = {pid_ext_manual, pid_int_manual, second_ramp, remote_mode, inching_function,
                     dir_clockwise, power_enable, run_ramp};
  logic [11:0] ra [4] = '{`OFS_STOP_METHOD, `OFS_CTRL_METHOD, `OFS_CUR_FILT, `OFS_SLIP_FILT};
  logic [15:0] rv [4] = '{16'h0000, 16'h0000, 16'h0032, 16'h01F4};
  logic [15:0] pat [4] = '{16'h0017, 16'h602A, 16'h9F00, 16'h0036};
  // enabled but never started: the last pattern leaves output power off
  logic [7:0]  ev [4] = '{8'h17, 8'hEA, 8'h00, 8'h34};
  // short ms tick keeps filter activity within the run
  drive_cmd_decoder #(.CLK_KHZ(4)) dut_u (.*);
  cmd_source_model src_u (.*);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
    if (fault_reset === 1'b1)
      n_pulse++;
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    begin
      num_checks++;
      if (g !== x)
      begin
        n_fail++;
        $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  // outputs follow one edge after the store, so three edges settle them
  task wr(input [1:0] s, input [11:0] a, input [31:0] d);
    begin
      src_u.xfer(s, 1'b1, a, d, q, e);
      repeat (3) @(posedge pclk);
    end
  endtask
  task rd(input [1:0] s, input [11:0] a);
    src_u.xfer(s, 1'b0, a, 32'h0, q, e);
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    n_fail++;
    print_verdict;
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rd(2'h1, ra[i]);
      chk("reset value", {16'h0, rv[i]}, q);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(2'h1, `OFS_CMD_WORD, {16'hFFFF, pat[i]});
      rd(2'h1, `OFS_CMD_WORD);
      chk("cmd readback", {16'h0, pat[i] & 16'h60FF}, q);
      chk("decoded", {24'h0, ev[i]}, st);
    end
    for (int m = 0; m < 3; m++)
    begin
      wr(2'h1, `OFS_STOP_METHOD, 32'(m));
      wr(2'h1, `OFS_CMD_WORD, 32'h3);
      wr(2'h1, `OFS_CMD_WORD, 32'h2);
      chk("power after stop", 32'(m != 1), power_enable);
      chk("quick ramp", 32'(m == 2), quick_stop_ramp);
      repeat (20) @(posedge pclk);
    end
    wr(2'h1, `OFS_STOP_METHOD, 32'h3);
    rd(2'h1, `OFS_STOP_METHOD);
    chk("stop mode kept", 32'h2, q);
    wr(2'h1, `OFS_STOP_METHOD, 32'h1);
    wr(2'h1, `OFS_CMD_WORD, 32'h3);
    di_three_wire_stop <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("input stop coasts", 32'h0, power_enable);
    di_three_wire_stop <= 1'b0;
    di_reverse <= 1'b1;
    panel_run <= 1'b1;
    wr(2'h1, `OFS_STOP_METHOD, 32'h0);
    wr(2'h2, `OFS_CMD_WORD, 32'h1);
    chk("plc write refused", 32'h1, e);
    wr(2'h0, `OFS_CMD_WORD, 32'h1);
    chk("panel write refused", 32'h1, e);
    rd(2'h2, `OFS_CMD_WORD);
    chk("cmd unchanged", 32'h3, q);
    di_reverse <= 1'b0;
    panel_run <= 1'b0;
    wr(2'h1, `OFS_CMD_WORD, 32'h43);
    chk("quick stop bit", 32'h1, quick_stop_ramp);
    fault_active <= 1'b1;
    wr(2'h1, `OFS_CMD_WORD, 32'h83);
    fault_active <= 1'b0;
    wr(2'h1, `OFS_CMD_WORD, 32'h3);
    wr(2'h1, `OFS_CMD_WORD, 32'h83);
    chk("fault reset pulses", 32'h1, n_pulse);
    wr(2'h1, `OFS_CTRL_METHOD, 32'h3);
    chk("vector mode", 32'h1, vector_mode);
    chk("no menu from network", 32'h0, guided_setup_menu);
    wr(2'h0, `OFS_CTRL_METHOD, 32'h0);
    wr(2'h0, `OFS_CTRL_METHOD, 32'h3);
    chk("menu from panel", 32'h1, guided_setup_menu);
    rd(2'h1, `OFS_STATUS);
    chk("status menu", 32'h1, q[0]);
    wr(2'h1, `OFS_STATUS, 32'h1);
    chk("menu cleared", 32'h0, guided_setup_menu);
    wr(2'h1, `OFS_SRC_SEL, 32'h2);
    wr(2'h2, `OFS_CMD_WORD, 32'h1);
    chk("plc write taken", 32'h0, e);
    wr(2'h1, `OFS_CMD_WORD, 32'h3);
    chk("network now refused", 32'h1, e);
    rd(2'h1, `OFS_CMD_WORD);
    chk("cmd from plc", 32'h1, q);
    wr(2'h1, `OFS_CUR_FILT, 32'h2710);
    rd(2'h1, `OFS_CUR_FILT);
    chk("filter limit", 32'h32, q);
    wr(2'h1, `OFS_CUR_FILT, 32'h270F);
    chk("cur filter out", 32'h270F, current_filter_time_o);
    wr(2'h1, `OFS_CUR_FILT, 32'h0);
    chk("current passthrough", 32'h0100, current_filtered);
    rd(2'h1, `OFS_CUR_OUT);
    chk("current readback", 32'h0100, q);
    wr(2'h1, `OFS_SLIP_FILT, 32'h0);
    chk("slip filter out", 32'h0, slip_filter_time_o);
    chk("slip passthrough", 32'h0040, slip_filtered);
    rd(2'h1, 12'h040);
    chk("unmapped", 32'h1, e);
    print_verdict;
  end
endmodule
